// File: test/icc_pin_model.sv
/*
 Far-side model of the capture pin: a burst of square pulses.
 Assumes go is one clock wide and that busy is polled on ref_clk.
*/
module icc_pin_model (
    input  wire logic       clk,    // System clock
    input  wire logic       go,     // Start a burst
    input  wire logic [4:0] pulses, // Pulses in the burst
    input  wire logic [7:0] half,   // Half period in clocks
    output logic            pin,    // Capture pin level
    output logic            busy    // Burst in progress
);
    timeunit 1ns;
    timeprecision 1ps;
    int i; // Edge index
    initial begin
        pin  = 1'b0;
        busy = 1'b0;
    end
    // --------------------------------------------
    // Burst engine: pin idles low between bursts
    // --------------------------------------------
    always begin
        @(posedge clk);
        if (go === 1'b1) begin
            busy <= 1'b1;
            for (i = 0; i < 2 * pulses; i++) begin
                repeat (half) @(posedge clk);
                pin <= ~pin;
            end
            repeat (half) @(posedge clk);
            busy <= 1'b0;
        end
    end
endmodule // icc_pin_model

// File: test/input_capture_control_test.sv
/*
 Self-checking bench for the input capture channel.
 Assumes icc_pin_model drives the pin; the bench drives timer ticks, cascade tied low.
*/
module input_capture_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [2:0] mode; logic [1:0] cpi; logic [4:0] n;
        logic [3:0] irqs; logic [2:0] caps; logic slp;
    } icc_case_s;
    // Mode, interrupt divider, pulses, interrupts, captures, sleep
    localparam icc_case_s TBL [10] = '{
        '{3'h3, 2'h3, 5'd4,  4'd1, 3'd4, 1'b0}, '{3'h2, 2'h1, 5'd4,  4'd2, 3'd4, 1'b0},
        '{3'h3, 2'h2, 5'd3,  4'd1, 3'd3, 1'b0},
        '{3'h1, 2'h3, 5'd2,  4'd4, 3'd4, 1'b0}, '{3'h4, 2'h0, 5'd8,  4'd2, 3'd2, 1'b0},
        '{3'h5, 2'h0, 5'd16, 4'd1, 3'd1, 1'b0}, '{3'h0, 2'h0, 5'd4,  4'd0, 3'd0, 1'b0},
        '{3'h6, 2'h0, 5'd4,  4'd0, 3'd0, 1'b0}, '{3'h7, 2'h0, 5'd4,  4'd0, 3'd0, 1'b0},
        '{3'h7, 2'h0, 5'd4,  4'd4, 3'd0, 1'b1}};
    // Time base codes of the three timers, in tick bit order
    localparam logic [2:0] TSC [3] = '{icc_pkg::TSEL_T1, icc_pkg::TSEL_T2, icc_pkg::TSEL_T3};
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        ref_clk    = 1'b0;         // System clock
    logic        arst_n     = 1'b0;         // Reset, low
    logic [1:0]  addr       = 2'h0;         // Register index
    logic [15:0] wr_data    = 16'h0000;     // Write data
    logic        wr_stb     = 1'b0;         // Write strobe
    logic        rd_stb     = 1'b0;         // Read strobe
    logic        idle_mode  = 1'b0;         // Processor idle
    logic        sleep_mode = 1'b0;         // Processor asleep
    logic [31:0] src_evt    = 32'h0000_0000; // Source events
    logic [2:0]  tick       = 3'h0;         // Timer ticks 1 to 3
    logic        pin_go     = 1'b0;         // Burst start
    logic [4:0]  pin_n      = 5'h00;        // Burst length
    logic [7:0]  pin_half   = 8'h04;        // Burst half period
    logic [15:0] rd_data;                   // Read data
    logic        cap_pin, pin_busy, capture_irq, cap_out, wrap; // Pin and events
    logic [15:0] v0, v1;                    // Captured values
    int          err_total = 0, total_checks = 0, irq_n = 0, cap_n = 0, i;
    icc_case_s   c;                         // Current table row

    icc_top uut (.ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .cap_pin(cap_pin),
        .idle_mode(idle_mode), .sleep_mode(sleep_mode), .t1_tick(tick[0]), .t2_tick(tick[1]),
        .t3_tick(tick[2]), .src_evt(src_evt), .casc_wrap_in(1'b0), .casc_cap_in(1'b0),
        .casc_wrap_out(wrap), .casc_cap_out(cap_out), .capture_irq(capture_irq));
    icc_pin_model pin_src (.clk(ref_clk), .go(pin_go), .pulses(pin_n), .half(pin_half),
        .pin(cap_pin), .busy(pin_busy));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // Event pulses last one cycle; count them mid-cycle, where they are settled
    always @(negedge ref_clk) begin
        if (capture_irq === 1'b1) irq_n++;
        if (cap_out === 1'b1) cap_n++;
    end
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= 1'b1;
        @(posedge ref_clk);
        wr_stb  <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        @(negedge ref_clk);
        d = rd_data;
    endtask
    task automatic rd_chk(input logic [1:0] a, input logic [15:0] exp, input string what);
        logic [15:0] d;
        rd(a, d);
        chk(what, exp, d);
    endtask
    // Burst on the pin, waiting for the model under a bound
    task automatic pulses(input logic [4:0] n, input logic [7:0] h);
        int k;
        @(posedge ref_clk);
        pin_n    <= n;
        pin_half <= h;
        pin_go   <= 1'b1;
        @(posedge ref_clk);
        pin_go   <= 1'b0;
        for (k = 0; k < 3000; k++) begin
            @(posedge ref_clk);
            if (pin_busy !== 1'b1) break;
        end
        if (k == 3000) begin
            err_total++;
            finish_test();
        end
        repeat (4) @(posedge ref_clk);
    endtask
    // Switch the channel off and empty the buffer
    task automatic drain();
        wr(icc_pkg::ADDR_CTL_ONE, 16'h0000);
        repeat (4) rd(icc_pkg::ADDR_BUF, v0);
    endtask
    task automatic finish_test();
        if (err_total == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd_chk(icc_pkg::ADDR_CTL_ONE, 16'h0000, "ctl_one reset");
        rd_chk(icc_pkg::ADDR_CTL_TWO, 16'h000D, "ctl_two reset");
        wr(icc_pkg::ADDR_CTL_ONE, 16'hFFFF);
        rd_chk(icc_pkg::ADDR_CTL_ONE, 16'h3C67, "ctl_one mask");
        wr(icc_pkg::ADDR_CTL_TWO, 16'hFFFF);
        rd_chk(icc_pkg::ADDR_CTL_TWO, 16'h01DF, "ctl_two mask");
        rd_chk(2'h3, 16'h0000, "unmapped");
        wr(icc_pkg::ADDR_CTL_TWO, 16'h0000);
        wr(icc_pkg::ADDR_CTL_ONE, 16'h0000);
        // Every mode at least once; the cheap half period keeps runs short
        for (i = 0; i < 10; i++) begin
            c = TBL[i];
            @(posedge ref_clk);
            sleep_mode <= c.slp;
            wr(icc_pkg::ADDR_CTL_ONE, {3'h0, icc_pkg::TSEL_SYS, 3'h0, c.cpi, 2'h0, c.mode});
            irq_n = 0;
            cap_n = 0;
            pulses(c.n, 8'h04);
            chk("irq count", {12'h000, c.irqs}, irq_n[15:0]);
            chk("capture count", {13'h0000, c.caps}, cap_n[15:0]);
            if (c.mode != 3'h7) rd_chk(icc_pkg::ADDR_CTL_ONE, {3'h0, icc_pkg::TSEL_SYS, 3'h0,
                c.cpi, 1'b0, (c.caps != 3'h0), c.mode}, "ctl_one status");
            @(posedge ref_clk);
            sleep_mode <= 1'b0;
            drain();
        end
        // Overflow: fifth capture is dropped and flagged
        wr(icc_pkg::ADDR_CTL_ONE, 16'h1C13);
        rd_chk(icc_pkg::ADDR_CTL_ONE, 16'h1C03, "ovf write");
        pulses(5'd5, 8'd10);
        rd_chk(icc_pkg::ADDR_CTL_ONE, 16'h1C1B, "ovf set");
        rd(icc_pkg::ADDR_BUF, v0);
        rd(icc_pkg::ADDR_BUF, v1);
        chk("capture spacing", 16'h000A, v1 - v0);
        repeat (2) rd(icc_pkg::ADDR_BUF, v0);
        rd_chk(icc_pkg::ADDR_CTL_ONE, 16'h1C03, "ovf clear");
        rd_chk(icc_pkg::ADDR_BUF, 16'h0000, "empty buffer");
        // Trigger mode: counter held until the source fires
        wr(icc_pkg::ADDR_CTL_TWO, 16'h0081);
        pulses(5'd1, 8'd10);
        rd_chk(icc_pkg::ADDR_CTL_ONE, 16'h1C0B, "held capture");
        rd_chk(icc_pkg::ADDR_BUF, 16'h0000, "held value");
        rd_chk(icc_pkg::ADDR_CTL_TWO, 16'h0081, "not triggered");
        @(posedge ref_clk);
        src_evt <= 32'h0000_0002;
        @(posedge ref_clk);
        src_evt <= 32'h0000_0000;
        rd_chk(icc_pkg::ADDR_CTL_TWO, 16'h00C1, "triggered");
        pulses(5'd2, 8'd10);
        rd(icc_pkg::ADDR_BUF, v0);
        rd(icc_pkg::ADDR_BUF, v1);
        chk("run after trigger", 16'h000A, v1 - v0);
        drain();
        wr(icc_pkg::ADDR_CTL_TWO, 16'h0000);
        // Idle stop: counter held clear and no capture taken while the processor idles
        wr(icc_pkg::ADDR_CTL_ONE, 16'h3C03);
        @(posedge ref_clk);
        idle_mode <= 1'b1;
        pulses(5'd2, 8'd10);
        rd(icc_pkg::ADDR_BUF, v0);
        rd(icc_pkg::ADDR_BUF, v1);
        chk("idle spacing", 16'h0000, v1 - v0);
        // Timer ticks: each code follows only its own timer; a clear
        // stop bit keeps the channel running while the processor idles
        for (i = 0; i < 3; i++) begin
            @(posedge ref_clk);
            tick <= 3'h1 << i;
            wr(icc_pkg::ADDR_CTL_ONE, {3'h0, TSC[i], 10'h003});
            pulses(5'd2, 8'd10);
            rd(icc_pkg::ADDR_BUF, v0);
            rd(icc_pkg::ADDR_BUF, v1);
            chk("timer spacing", 16'h0014, v1 - v0);
            drain();
        end
        // Counter wrap: a tick held high crosses FFFF in one pass
        wr(icc_pkg::ADDR_CTL_ONE, {3'h0, icc_pkg::TSEL_T3, 10'h003});
        for (i = 0; i < 66000 && wrap !== 1'b1; i++) @(negedge ref_clk);
        chk("counter wrap", 16'h0001, {15'h0000, wrap});
        finish_test();
    end
endmodule // input_capture_control_test

// File: verilog/icc_fifo.sv
/*
 Four-entry capture buffer for one capture channel.
 Assumes the caller never pushes while full nor pops while empty.
*/
module icc_fifo (
    input  wire logic        clk,    // System clock
    input  wire logic        rst_n,  // Synchronised reset, low
    input  wire logic        push,   // Store din
    input  wire logic [15:0] din,    // Captured value
    input  wire logic        pop,    // Drop oldest entry
    output logic      [15:0] dout,   // Oldest entry
    output logic             full,   // All entries used
    output logic             empty   // No entry held
);

    // ------------------------------------------------
    // State
    // ------------------------------------------------
    typedef struct packed {
        logic [icc_pkg::BUF_DEPTH-1:0][15:0] mem; // Entries
        logic [1:0] wp;                           // Write pointer
        logic [1:0] rp;                           // Read pointer
        logic [2:0] cnt;                          // Fill level
    } icc_fifo_s;

    icc_fifo_s st;
    icc_fifo_s next_st;

    assign dout  = st.mem[st.rp];
    assign full  = (st.cnt == 3'(icc_pkg::BUF_DEPTH));
    assign empty = (st.cnt == 3'h0);

    // Pointer and level update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = din;
            next_st.wp         = st.wp + 2'h1;
        end
        if (pop) begin
            next_st.rp = st.rp + 2'h1;
        end
        next_st.cnt = st.cnt + 3'(push) - 3'(pop);
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule // icc_fifo

// File: verilog/icc_pkg.sv
/*
 Constants, register layout and reset values of the input
 capture channel control block.
 Assumes a single 100 MHz clock and a plain register port.
*/
package icc_pkg;

    // ------------------------------------------------
    // Register map (word indices on the register port)
    // ------------------------------------------------
    localparam logic [1:0]  ADDR_CTL_ONE = 2'h0;
    localparam logic [1:0]  ADDR_CTL_TWO = 2'h1;
    localparam logic [1:0]  ADDR_BUF     = 2'h2;
    localparam logic [15:0] RST_CTL_ONE  = 16'h0000;
    localparam logic [15:0] RST_CTL_TWO  = 16'h000D;

    // ------------------------------------------------
    // Field positions
    // ------------------------------------------------
    localparam int IDLE_STOP_BIT = 13;
    localparam int TSEL_LSB      = 10;
    localparam int CPI_LSB       = 5;
    localparam int OVF_BIT       = 4;
    localparam int BNE_BIT       = 3;
    localparam int MODE_LSB      = 0;
    localparam int CASC_BIT      = 8;
    localparam int SOT_BIT       = 7;
    localparam int TRIG_BIT      = 6;
    localparam int SRC_LSB       = 0;

    // ------------------------------------------------
    // Codes and counts
    // ------------------------------------------------
    localparam logic [2:0] TSEL_SYS = 3'h7;
    localparam logic [2:0] TSEL_T1  = 3'h4;
    localparam logic [2:0] TSEL_T2  = 3'h1;
    localparam logic [2:0] TSEL_T3  = 3'h0;
    localparam logic [4:0] SRC_NONE = 5'h00;
    localparam logic [3:0] PRE4_LAST  = 4'h3;
    localparam logic [3:0] PRE16_LAST = 4'hF;
    localparam int         BUF_DEPTH  = 4;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;

    typedef enum logic [2:0] {
        ICC_OFF   = 3'h0,
        ICC_BOTH  = 3'h1,
        ICC_FALL  = 3'h2,
        ICC_RISE  = 3'h3,
        ICC_PRE4  = 3'h4,
        ICC_PRE16 = 3'h5,
        ICC_UNUSED = 3'h6,
        ICC_WAKE  = 3'h7
    } icc_mode_e;

endpackage

// File: verilog/icc_top.sv
/*
 Input capture channel: control registers, time base counter,
 edge detection, capture buffer and interrupt event.
 Assumes inputs are synchronous to ref_clk; timer ticks and
 source events are one-cycle pulses from neighbouring blocks.
*/
module icc_top #(
    parameter bit ODD_CHANNEL = 1'b1 // Low half when cascaded
) (
    input  wire logic        ref_clk,      // 100 MHz clock
    input  wire logic        arst_n,       // Async reset, low
    input  wire logic [1:0]  addr,         // Register index
    input  wire logic [15:0] wr_data,      // Write data
    input  wire logic        wr_stb,       // Write strobe
    input  wire logic        rd_stb,       // Read strobe
    output logic      [15:0] rd_data,      // Read data, next cycle
    input  wire logic        cap_pin,      // Capture input pin
    input  wire logic        idle_mode,    // Processor in Idle
    input  wire logic        sleep_mode,   // Processor in Sleep
    input  wire logic        t1_tick,      // Timer 1 clock enable
    input  wire logic        t2_tick,      // Timer 2 clock enable
    input  wire logic        t3_tick,      // Timer 3 clock enable
    input  wire logic [31:0] src_evt,      // Events by source code
    input  wire logic        casc_wrap_in, // Partner low wrap
    input  wire logic        casc_cap_in,  // Partner capture
    output logic             casc_wrap_out,// Low counter wraps
    output logic             casc_cap_out, // Capture taken
    output logic             capture_irq   // Interrupt event pulse
);

    // ------------------------------------------------
    // Reset release
    // ------------------------------------------------
    logic [1:0] rst_q; // Release synchroniser
    logic       rst_n; // Synchronised reset

    // Two flops so reset leaves on a clean edge
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_q <= 2'b00;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // ------------------------------------------------
    // State
    // ------------------------------------------------
    typedef struct packed {
        logic        idle_stop; // Halt in Idle
        logic [2:0]  tsel;      // Time base select
        logic [1:0]  cpi;       // Captures per interrupt
        logic        ovf;       // Overflow flag
        logic [2:0]  mode;      // Capture mode
        logic        casc;      // Cascade enable
        logic        sot;       // Trigger (1) or sync (0)
        logic        trig;      // Trigger status
        logic [4:0]  src;       // Source select
        logic [15:0] cnt;       // Capture counter
        logic        pin_q;     // Pin, last cycle
        logic [3:0]  pre;       // Prescaler edge count
        logic [1:0]  icnt;      // Captures since interrupt
        logic        div;       // System clock divider
        logic [15:0] rdata;     // Read data
        logic        irq;       // Interrupt pulse
        logic [2:0]  lvl;       // Buffer level mirror
    } icc_top_s;

    icc_top_s st;
    icc_top_s next_st;

    // ------------------------------------------------
    // Buffer
    // ------------------------------------------------
    logic        push;    // Capture stored
    logic        pop;     // Buffer read
    logic [15:0] buf_out; // Oldest value
    logic        full;    // Buffer full
    logic        empty;   // Buffer empty

    icc_fifo u_fifo (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .push  (push),
        .din   (st.cnt),
        .pop   (pop),
        .dout  (buf_out),
        .full  (full),
        .empty (empty)
    );

    // ------------------------------------------------
    // Combinational helpers
    // ------------------------------------------------
    logic        tb_tick;  // Selected time base edge
    logic        step;     // Counter advances
    logic        active;   // Channel counting/capturing
    logic        src_hit;  // Selected source fired
    logic        run;      // Time base released
    logic        clr;      // Sync reset of counter
    logic        rise;     // Pin rising edge
    logic        fall;     // Pin falling edge
    logic        cap_evt;  // Capture event
    logic        lo_half;  // Channel counts from own base
    logic        wr_one;   // Write to first register
    logic        wr_two;   // Write to second register
    logic [15:0] ctl_one;  // First register read view
    logic [15:0] ctl_two;  // Second register read view

    assign lo_half = ODD_CHANNEL || !st.casc;
    assign rise    = cap_pin && !st.pin_q;
    assign fall    = !cap_pin && st.pin_q;
    assign wr_one  = wr_stb && (addr == icc_pkg::ADDR_CTL_ONE);
    assign wr_two  = wr_stb && (addr == icc_pkg::ADDR_CTL_TWO);
    assign pop     = rd_stb && (addr == icc_pkg::ADDR_BUF) && !empty;
    assign push    = cap_evt && !full;

    // Register views; unimplemented bits stay zero
    assign ctl_one = {2'b00, st.idle_stop, st.tsel, 3'b000, st.cpi,
                      st.ovf, !empty, st.mode};
    assign ctl_two = {7'h00, st.casc, st.sot, st.trig, 1'b0, st.src};

    // Time base source; reserved codes give no edge
    always_comb begin
        case (st.tsel)
            icc_pkg::TSEL_SYS: tb_tick = st.div;
            icc_pkg::TSEL_T1:  tb_tick = t1_tick;
            icc_pkg::TSEL_T2:  tb_tick = t2_tick;
            icc_pkg::TSEL_T3:  tb_tick = t3_tick;
            default:           tb_tick = 1'b0;
        endcase
    end

    // Channel gating: off, unused and wake modes do not count
    always_comb begin
        case (icc_pkg::icc_mode_e'(st.mode))
            icc_pkg::ICC_BOTH,
            icc_pkg::ICC_FALL,
            icc_pkg::ICC_RISE,
            icc_pkg::ICC_PRE4,
            icc_pkg::ICC_PRE16: active = 1'b1;
            default:            active = 1'b0;
        endcase
        if (st.idle_stop && idle_mode) begin
            active = 1'b0;
        end
    end

    // Source vector is indexed by code; software keeps 24-28
    // as triggers and avoids its own interrupt
    assign src_hit = (st.src != icc_pkg::SRC_NONE) && src_evt[st.src];
    assign run     = !st.sot || st.trig;
    assign clr     = !st.sot && src_hit;
    assign step    = lo_half ? tb_tick : casc_wrap_in;
    assign casc_wrap_out = active && run && !clr && step &&
                           (st.cnt == icc_pkg::CNT_MAX);

    // Edge selection per mode; high half follows partner
    always_comb begin
        case (icc_pkg::icc_mode_e'(st.mode))
            icc_pkg::ICC_BOTH:  cap_evt = rise || fall;
            icc_pkg::ICC_FALL:  cap_evt = fall;
            icc_pkg::ICC_RISE:  cap_evt = rise;
            icc_pkg::ICC_PRE4:  cap_evt = rise && (st.pre[1:0] == icc_pkg::PRE4_LAST[1:0]);
            icc_pkg::ICC_PRE16: cap_evt = rise && (st.pre == icc_pkg::PRE16_LAST);
            default:            cap_evt = 1'b0;
        endcase
        if (!lo_half) begin
            cap_evt = casc_cap_in;
        end
        cap_evt = cap_evt && active;
    end
    assign casc_cap_out = cap_evt;

    // ------------------------------------------------
    // Next state
    // ------------------------------------------------
    always_comb begin
        next_st       = st;
        next_st.pin_q = cap_pin;
        next_st.div   = !st.div;
        next_st.irq   = 1'b0;
        next_st.rdata = 16'h0000;

        // Software writes; overflow and buffer status bits are not writable, trigger status is
        if (wr_one) begin
            next_st.idle_stop = wr_data[icc_pkg::IDLE_STOP_BIT];
            next_st.tsel      = wr_data[icc_pkg::TSEL_LSB +: 3];
            next_st.cpi       = wr_data[icc_pkg::CPI_LSB +: 2];
            next_st.mode      = wr_data[icc_pkg::MODE_LSB +: 3];
        end
        if (wr_two) begin
            next_st.casc = wr_data[icc_pkg::CASC_BIT];
            next_st.sot  = wr_data[icc_pkg::SOT_BIT];
            next_st.trig = wr_data[icc_pkg::TRIG_BIT];
            next_st.src  = wr_data[icc_pkg::SRC_LSB +: 5];
        end

        // Hardware trigger wins over a software clear
        if (st.sot && src_hit) begin
            next_st.trig = 1'b1;
        end

        // Counter: held clear, sync reset, or counting
        if (!active || !run) begin
            next_st.cnt = 16'h0000;
        end else if (clr) begin
            next_st.cnt = 16'h0000;
        end else if (step) begin
            next_st.cnt = st.cnt + 16'h0001;
        end

        // Prescaler counts rising edges only in its modes
        if (!active || st.mode < icc_pkg::ICC_PRE4) begin
            next_st.pre = 4'h0;
        end else if (rise) begin
            next_st.pre = (st.mode == icc_pkg::ICC_PRE4 &&
                           st.pre[1:0] == icc_pkg::PRE4_LAST[1:0]) ?
                          4'h0 : st.pre + 4'h1;
        end

        // Interrupt pacing
        if (!active) begin
            next_st.icnt = 2'h0;
        end
        if (cap_evt) begin
            if (st.mode == icc_pkg::ICC_BOTH || st.icnt == st.cpi) begin
                next_st.irq  = 1'b1;
                next_st.icnt = 2'h0;
            end else begin
                next_st.icnt = st.icnt + 2'h1;
            end
        end
        if (st.mode == icc_pkg::ICC_WAKE && rise && (sleep_mode || idle_mode)) begin
            next_st.irq = 1'b1;
        end

        // Level mirror: the buffer has no count port, and the
        // overflow flag must know when the last entry leaves
        next_st.lvl = st.lvl + 3'(push) - 3'(pop);

        // Overflow clears once the buffer is read empty; a new
        // overflow in the same cycle wins
        if (pop && st.ovf == 1'b1 && st.lvl == 3'h1 && !push) begin
            next_st.ovf = 1'b0;
        end
        if (cap_evt && full) begin
            next_st.ovf = 1'b1;
        end

        // Read data path
        if (rd_stb) begin
            case (addr)
                icc_pkg::ADDR_CTL_ONE: next_st.rdata = ctl_one;
                icc_pkg::ADDR_CTL_TWO: next_st.rdata = ctl_two;
                icc_pkg::ADDR_BUF:     next_st.rdata = empty ? 16'h0000 : buf_out;
                default:               next_st.rdata = 16'h0000;
            endcase
        end
    end

    // State register; reset values of the two controls
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st           <= '0;
            st.src       <= icc_pkg::RST_CTL_TWO[4:0];
            st.sot       <= icc_pkg::RST_CTL_TWO[icc_pkg::SOT_BIT];
            st.casc      <= icc_pkg::RST_CTL_TWO[icc_pkg::CASC_BIT];
            st.idle_stop <= icc_pkg::RST_CTL_ONE[icc_pkg::IDLE_STOP_BIT];
        end else begin
            st <= next_st;
        end
    end

    assign rd_data     = st.rdata;
    assign capture_irq = st.irq;

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_full_cap;
        cap_evt && full;
    endsequence
    sequence s_flag_up;
        ##1 st.ovf && ctl_one[icc_pkg::OVF_BIT];
    endsequence

    ovf_on_full_a: assert property (s_full_cap |-> s_flag_up)
        else $error("overflow not flagged");
    ovf_hold_a: assert property (st.ovf && !pop |=> st.ovf)
        else $error("overflow dropped without read");
    bne_level_a: assert property (ctl_one[icc_pkg::BNE_BIT] == (st.lvl != 3'h0))
        else $error("buffer flag wrong");
    hold_zero_a: assert property (st.sot && !st.trig && !src_hit |=> st.cnt == 16'h0000)
        else $error("counter ran without trigger");
    trig_set_a: assert property (st.sot && src_hit |=> st.trig)
        else $error("trigger not recorded");
    sync_clr_a: assert property (active && clr |=> st.cnt == 16'h0000)
        else $error("sync did not clear counter");
    off_quiet_a: assert property ((st.mode == icc_pkg::ICC_OFF || st.mode == icc_pkg::ICC_UNUSED)
                                  |-> !cap_evt ##1 st.cnt == 16'h0000)
        else $error("disabled channel active");
    idle_halt_a: assert property (st.idle_stop && idle_mode |-> !cap_evt && !casc_wrap_out)
        else $error("channel ran in idle");
    wrap_zero_a: assert property (casc_wrap_out |=> st.cnt == 16'h0000)
        else $error("counter did not wrap");
    unimpl_zero_a: assert property (ctl_two[15:9] == 7'h00 && ctl_two[5] == 1'b0 &&
                                    ctl_one[15:14] == 2'b00 && ctl_one[9:7] == 3'b000)
        else $error("unimplemented bit set");
    both_irq_a: assert property (st.mode == icc_pkg::ICC_BOTH && cap_evt |=> capture_irq)
        else $error("edge mode missed interrupt");
    rd_next_a: assert property (rd_stb && addr == icc_pkg::ADDR_CTL_TWO |=> rd_data == $past(ctl_two))
        else $error("read data late or wrong");

    // ------------------------------------------------
    // Capture path, interrupt pacing and wake mode
    // ------------------------------------------------
    sequence s_stored;
        push ##1 !empty;
    endsequence
    sequence s_read_out;
        ##1 rd_data == $past(buf_out);
    endsequence

    // Edge choice in rise and fall modes, then storage and read-out of the oldest entry
    rise_cap_a: assert property (st.mode == icc_pkg::ICC_RISE && active && lo_half && rise |-> cap_evt)
        else $error("rising edge not captured");
    fall_cap_a: assert property (st.mode == icc_pkg::ICC_FALL && active && lo_half && fall |-> cap_evt)
        else $error("falling edge not captured");
    cap_store_a: assert property (cap_evt && !full |-> s_stored)
        else $error("capture not stored");
    rd_buf_a: assert property (rd_stb && addr == icc_pkg::ADDR_BUF && !empty |-> s_read_out)
        else $error("buffer read wrong");

    // Outside both-edge mode no capture interrupt before its count; wake edges interrupt in sleep or idle
    cpi_skip_a: assert property (cap_evt && st.mode != icc_pkg::ICC_BOTH && st.icnt != st.cpi
                                 |=> !capture_irq)
        else $error("interrupt before its count");
    wake_irq_a: assert property (st.mode == icc_pkg::ICC_WAKE && rise && (sleep_mode || idle_mode)
                                 |=> capture_irq)
        else $error("wake edge missed");
    wake_quiet_a: assert property (st.mode == icc_pkg::ICC_WAKE |-> !cap_evt && !push)
        else $error("wake mode captured");

endmodule // icc_top
